//--- cbsm_map.svh
// Purpose: offsets, field positions, reset values of the control bit matrix
// Assumes: included by its bare name after cbsm_pkg is compiled
// Notes:   definitions only
`ifndef CBSM_MAP_SVH
`define CBSM_MAP_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define CBSM_NUM_SEL      24
`define CBSM_NUM_CTL      32
`define CBSM_NUM_SRC      6'h24
`define CBSM_NUM_PIN      20
`define CBSM_SEL_W        6

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CBSM_OFF_SEL0     8'h00
`define CBSM_OFF_OUTSEL   8'h18
`define CBSM_OFF_CTLSTAT  8'h1C
`define CBSM_ADR_W        8

// ****************************************************************
// field layout
// ****************************************************************
`define CBSM_SEL_PER_WORD 4
`define CBSM_SEL_LANE_W   8

// ****************************************************************
// reset values
// ****************************************************************
`define CBSM_DFLT_BASE    cbsm_pkg::src_ll_write
`define CBSM_DFLT_CTL17   cbsm_pkg::src_q24
`define CBSM_DFLT_CTL23   cbsm_pkg::src_backplane_fast_status_wr1
`define CBSM_RST_OUTSEL   8'h00
`define CBSM_RST_WORD     32'h0000_0000

`endif

//--- cbsm_pkg.sv
// Purpose: types of the control bit matrix
// Assumes: nothing
// Notes:   source order matches the source vector built in cbsm_top
package cbsm_pkg;

	// ****************************************************************
	// source codes for control bits 1..24
	// ****************************************************************
	typedef enum logic [5:0] {
		src_ot_pos_ax1, src_ot_neg_ax1, src_home_ax1,
		src_ot_pos_ax2, src_ot_neg_ax2, src_home_ax2,
		src_gen_a_ax3,  src_gen_b_ax3,  src_home_ax3,
		src_gen_a_ax4,  src_gen_b_ax4,  src_gen_c_ax4,
		src_stb1_ax1, src_stb2_ax1, src_stb1_ax2,
		src_stb2_ax2, src_stb1_ax3, src_stb2_ax3,
		src_lv_a_ax4, src_lv_b_ax4,
		src_ll_write, src_ll_active,
		src_backplane_fast_status_wr1, src_backplane_fast_status_wr2, src_backplane_fast_status_wr3, src_backplane_fast_status_wr4,
		src_q12, src_q13, src_q14, src_q15,
		src_q24, src_q25, src_q40, src_q41, src_q56, src_q57
	} cbsm_src_e;

	typedef logic [5:0] cbsm_sel_t;

endpackage : cbsm_pkg

//--- cbsm_sync.sv
// Purpose: two-stage synchroniser for the faceplate pins
// Assumes: pins are asynchronous to clk_i
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
`include "cbsm_map.svh"

module cbsm_sync (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic [`CBSM_NUM_PIN-1:0] pin_i,
	output logic      [`CBSM_NUM_PIN-1:0] pin_o
);

	// ****************************************************************
	// two flops, only the second reads the first
	// ****************************************************************
	logic [`CBSM_NUM_PIN-1:0] meta_ff;
	logic [`CBSM_NUM_PIN-1:0] sync_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
		end
	end

	assign pin_o = sync_ff;

endmodule : cbsm_sync
`default_nettype wire

//--- cbsm_bit_mux.sv
// Purpose: one selectable control bit
// Assumes: sources already in the clk_i domain
// Notes:   unknown codes give zero
`timescale 1ns/1ps
`default_nettype none
`include "cbsm_map.svh"

module cbsm_bit_mux (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic [`CBSM_SEL_W-1:0]   sel_i,
	input  wire logic [35:0]              src_i,
	input  wire logic                     ll_bit_i,
	output logic                          bit_o
);

	// ****************************************************************
	// select and register every cycle
	// ****************************************************************
	logic bit_ff;
	logic nxt_bit;

	always_comb begin
		if (sel_i == cbsm_pkg::src_ll_write) begin
			nxt_bit = ll_bit_i;
		end else if (sel_i < `CBSM_NUM_SRC) begin
			nxt_bit = src_i[sel_i];
		end else begin
			nxt_bit = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_ff <= 1'b0;
		end else begin
			bit_ff <= nxt_bit;
		end
	end

	assign bit_o = bit_ff;

endmodule : cbsm_bit_mux
`default_nettype wire

//--- cbsm_top.sv
// Purpose: control bit source matrix and faceplate output routing
// Assumes: one clock, synchronous reset, classic Wishbone slave
// Notes:   pins are synchronised, backplane and program inputs are not
//
// Functional notes
// - each of bits 1-24 has a selector
// - bits 25-32 fixed, program reads and writes
// - bits 17-22 reset to output-image bits
// - bits 23-24 reset to fast-status bits 1-2
// - overtravel and home inputs are sources
// - general and low-volt inputs are sources
// - strobe levels of axes 1-3 are sources
// - program-write source gives last written value
// - program-running flag is a source
// - any fast-status write bit selectable
// - output-image bits 12-15, 24, 25, 40, 41, 56, 57 are sources
// - fast-status exchange: 4 in, 8 out
// - bits 1-8 always on image and fast-status
// - control bits feed program, follower, jump, wait
// - each faceplate output has a source choice
// - eight faceplate outputs, two per axis
// - program writes bits 1-24 only when selected
// - one 32-bit read of all bits
`timescale 1ns/1ps
`default_nettype none
`include "cbsm_map.svh"

module cbsm_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	// faceplate inputs
	input  wire logic        axis1_overtravel_pos_input_i,
	input  wire logic        axis1_overtravel_neg_input_i,
	input  wire logic        axis1_home_switch_input_i,
	input  wire logic        axis2_overtravel_pos_input_i,
	input  wire logic        axis2_overtravel_neg_input_i,
	input  wire logic        axis2_home_switch_input_i,
	input  wire logic        axis3_general_input_a_i,
	input  wire logic        axis3_general_input_b_i,
	input  wire logic        axis3_home_switch_input_i,
	input  wire logic        axis4_general_input_a_i,
	input  wire logic        axis4_general_input_b_i,
	input  wire logic        axis4_general_input_c_i,
	input  wire logic [5:0]  strobe_level_i,
	input  wire logic        axis4_low_volt_input_a_i,
	input  wire logic        axis4_low_volt_input_b_i,
	// on-board logic program
	input  wire logic        ll_active_i,
	input  wire logic        ll_ctl_wr_i,
	input  wire logic [4:0]  ll_ctl_idx_i,
	input  wire logic        ll_ctl_wdata_i,
	input  wire logic        ll_out_wr_i,
	input  wire logic [2:0]  ll_out_idx_i,
	input  wire logic        ll_out_wdata_i,
	output logic      [31:0] all_control_bits_word_o,
	// plc side
	input  wire logic [3:0]  backplane_fast_status_wr_i,
	output logic      [7:0]  backplane_fast_status_rd_o,
	input  wire logic [3:0]  plc_prog_ctl_q_i,
	input  wire logic [7:0]  plc_out_ctl_q_i,
	output logic      [7:0]  plc_in_image_o,
	// consumers
	output logic      [31:0] control_bits_1_to_32_o,
	// faceplate outputs
	output logic             axis1_ssr_output_o,
	output logic             axis1_low_volt_output_o,
	output logic             axis2_ssr_output_o,
	output logic             axis2_low_volt_output_o,
	output logic             axis3_ssr_output_o,
	output logic             axis3_low_volt_output_o,
	output logic             axis4_ssr_output_o,
	output logic             axis4_low_volt_output_o
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [`CBSM_NUM_PIN-1:0] pin_raw;
	logic [`CBSM_NUM_PIN-1:0] pin_s;
	logic [35:0]              src_vec;
	logic [`CBSM_SEL_W-1:0]   sel_ff [`CBSM_NUM_SEL];
	logic [`CBSM_NUM_CTL-1:0] ll_wr_ff;
	logic [`CBSM_NUM_SEL-1:0] mux_q;
	logic [`CBSM_NUM_CTL-1:0] ctl_word;
	logic [7:0]               out_sel_ff;
	logic [7:0]               ll_out_ff;
	logic [7:0]               face_ff;
	logic                     ack_ff;
	logic [31:0]              dat_ff;
	logic [31:0]              nxt_dat;
	logic                     req;
	logic                     wr_req;

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	assign pin_raw = {
		axis4_low_volt_input_b_i,
		axis4_low_volt_input_a_i,
		strobe_level_i,
		axis4_general_input_c_i,
		axis4_general_input_b_i,
		axis4_general_input_a_i,
		axis3_home_switch_input_i,
		axis3_general_input_b_i,
		axis3_general_input_a_i,
		axis2_home_switch_input_i,
		axis2_overtravel_neg_input_i,
		axis2_overtravel_pos_input_i,
		axis1_home_switch_input_i,
		axis1_overtravel_neg_input_i,
		axis1_overtravel_pos_input_i
	};

	cbsm_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (pin_raw),
		.pin_o (pin_s)
	);

	// ****************************************************************
	// source vector, order of cbsm_src_e
	// ****************************************************************
	// program-write slot is filled per bit inside the mux
	assign src_vec = {
		plc_out_ctl_q_i[5:0],
		plc_prog_ctl_q_i,
		backplane_fast_status_wr_i,
		ll_active_i,
		1'b0,
		pin_s
	};

	// ****************************************************************
	// wishbone handshake
	// ****************************************************************
	// answer one cycle after the request, dropped the next
	assign req    = cyc_i & stb_i & ~ack_ff;
	assign wr_req = req & we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// ****************************************************************
	// selectors, one per configurable bit
	// ****************************************************************
	function automatic logic [5:0] dflt_sel(input int idx);
		logic [5:0] base17;
		logic [5:0] base23;
		base17 = `CBSM_DFLT_CTL17;
		base23 = `CBSM_DFLT_CTL23;
		if (idx >= 16 && idx <= 21) begin
			dflt_sel = base17 + 6'(idx - 16);
		end else if (idx >= 22) begin
			dflt_sel = base23 + 6'(idx - 22);
		end else begin
			dflt_sel = `CBSM_DFLT_BASE;
		end
	endfunction : dflt_sel

	genvar g;
	generate
		for (g = 0; g < `CBSM_NUM_SEL; g++) begin : g_sel
			localparam int W = g / `CBSM_SEL_PER_WORD;
			localparam int L = g % `CBSM_SEL_PER_WORD;
			localparam logic [7:0] OFF = 8'(`CBSM_OFF_SEL0 + 4 * W);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sel_ff[g] <= dflt_sel(g);
				end else if (wr_req && adr_i == OFF && sel_i[L]) begin
					sel_ff[g] <= dat_i[L*`CBSM_SEL_LANE_W +: `CBSM_SEL_W];
				end
			end

			cbsm_bit_mux u_mux (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.sel_i    (sel_ff[g]),
				.src_i    (src_vec),
				.ll_bit_i (ll_wr_ff[g]),
				.bit_o    (mux_q[g])
			);
		end
	endgenerate

	// ****************************************************************
	// program writes to control bits
	// ****************************************************************
	// a refused write leaves the stored value, so switching the
	// source back to program control restores what it last wrote
	generate
		for (g = 0; g < `CBSM_NUM_CTL; g++) begin : g_llwr
			logic wr_ok;
			if (g < `CBSM_NUM_SEL) begin : g_cfg
				assign wr_ok = (sel_ff[g] == cbsm_pkg::src_ll_write);
			end else begin : g_fix
				assign wr_ok = 1'b1;
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ll_wr_ff[g] <= 1'b0;
				end else if (ll_ctl_wr_i && ll_ctl_idx_i == 5'(g) && wr_ok) begin
					ll_wr_ff[g] <= ll_ctl_wdata_i;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// control word and its consumers
	// ****************************************************************
	assign ctl_word = {ll_wr_ff[31:24], mux_q};
	assign all_control_bits_word_o    = ctl_word;
	assign control_bits_1_to_32_o     = ctl_word;
	assign plc_in_image_o             = ctl_word[7:0];
	assign backplane_fast_status_rd_o = ctl_word[7:0];

	// ****************************************************************
	// faceplate output routing
	// ****************************************************************
	// bit set = program controls the output, clear = plc
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_sel_ff <= `CBSM_RST_OUTSEL;
		end else if (wr_req && adr_i == `CBSM_OFF_OUTSEL && sel_i[0]) begin
			out_sel_ff <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ll_out_ff <= 8'h00;
		end else if (ll_out_wr_i && out_sel_ff[ll_out_idx_i]) begin
			ll_out_ff[ll_out_idx_i] <= ll_out_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			face_ff <= 8'h00;
		end else begin
			face_ff <= (out_sel_ff & ll_out_ff) |
			           (~out_sel_ff & plc_out_ctl_q_i);
		end
	end

	assign axis1_ssr_output_o      = face_ff[0];
	assign axis1_low_volt_output_o = face_ff[1];
	assign axis2_ssr_output_o      = face_ff[2];
	assign axis2_low_volt_output_o = face_ff[3];
	assign axis3_ssr_output_o      = face_ff[4];
	assign axis3_low_volt_output_o = face_ff[5];
	assign axis4_ssr_output_o      = face_ff[6];
	assign axis4_low_volt_output_o = face_ff[7];

	// ****************************************************************
	// read data
	// ****************************************************************
	always_comb begin
		nxt_dat = 32'h0000_0000;
		for (int i = 0; i < `CBSM_NUM_SEL; i++) begin
			if (adr_i == 8'(`CBSM_OFF_SEL0 + 4 * (i / 4))) begin
				nxt_dat[(i % 4) * 8 +: 6] = sel_ff[i];
			end
		end
		if (adr_i == `CBSM_OFF_OUTSEL) begin
			nxt_dat[7:0] = out_sel_ff;
		end
		if (adr_i == `CBSM_OFF_CTLSTAT) begin
			nxt_dat = ctl_word;
		end
	end

	// unmapped addresses answer with zero, writes there are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_ff <= `CBSM_RST_WORD;
		end else if (req && !we_i) begin
			dat_ff <= nxt_dat;
		end
	end

	assign dat_o = dat_ff;
	assign ack_o = ack_ff;

endmodule : cbsm_top
`default_nettype wire

//--- cbsm_top_chk_sva.sv
// Purpose: port checks of the control bit matrix
// Assumes: bound onto cbsm_top, one clock, reset high
// Notes:   sees ports only
`timescale 1ns/1ps
`default_nettype none
module cbsm_top_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  adr_i,
	input wire logic        we_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	input wire logic        ll_ctl_wr_i,
	input wire logic [4:0]  ll_ctl_idx_i,
	input wire logic        ll_ctl_wdata_i,
	input wire logic [31:0] all_control_bits_word_o,
	input wire logic [31:0] control_bits_1_to_32_o,
	input wire logic [7:0]  backplane_fast_status_rd_o,
	input wire logic [7:0]  plc_in_image_o
);
	// ****************
	// checks
	// ****************
	wire logic req;
	assign req = cyc_i && stb_i && !ack_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property (req |=> ack_o)
		else $error("ack not one cycle after request");
	unmapped_zero_a: assert property (req && !we_i && adr_i >= 8'h20 |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	word_copy_a: assert property (control_bits_1_to_32_o == all_control_bits_word_o)
		else $error("consumer word differs");
	fs_image_a: assert property (backplane_fast_status_rd_o == plc_in_image_o)
		else $error("fast status and image differ");
	fs_low_a: assert property (backplane_fast_status_rd_o == all_control_bits_word_o[7:0]
		|| backplane_fast_status_rd_o == $past(all_control_bits_word_o[7:0]))
		else $error("fast status not bits 1 to 8");
	fixed_write_a: assert property (ll_ctl_wr_i && ll_ctl_idx_i[4:3] == 2'b11 |=>
		all_control_bits_word_o[$past(ll_ctl_idx_i)] == $past(ll_ctl_wdata_i))
		else $error("fixed bit write lost");
	reset_clear_a: assert property ($fell(rst_i) |-> all_control_bits_word_o == 32'h0 && !ack_o)
		else $error("outputs not clear after reset");
	read_seen_c: cover property (ack_o && !we_i);
	fixed_seen_c: cover property (ll_ctl_wr_i && ll_ctl_idx_i == 5'h1F);
	image_seen_c: cover property (all_control_bits_word_o[23:16] != 8'h00);
endmodule : cbsm_top_chk
`default_nettype wire

//--- cbsm_plc_model.sv
// Purpose: plc cpu at the backplane side
// Assumes: one exchange every clock
// Notes:   image levels settle one clock after a request
`timescale 1ns/1ps
`default_nettype none
module cbsm_plc_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] fs_req_i,
	input  wire logic [3:0] prog_req_i,
	input  wire logic [7:0] out_req_i,
	input  wire logic [7:0] fs_rd_i,
	output logic      [3:0] fs_wr_o = 4'h0,
	output logic      [3:0] prog_o = 4'h0,
	output logic      [7:0] out_o = 8'h00,
	output logic      [7:0] seen_o = 8'h00
);
	// ****************
	// exchange
	// ****************
	always @(posedge clk_i) begin
		fs_wr_o <= fs_req_i;
		prog_o <= prog_req_i;
		out_o <= out_req_i;
		seen_o <= fs_rd_i;
	end
endmodule : cbsm_plc_model
`default_nettype wire

//--- cbsm_top_tb.sv
// Purpose: self-checking bench of the control bit matrix
// Assumes: classic wishbone, one clock
// Notes:   expectations queued, a monitor compares
`timescale 1ns/1ps
`default_nettype none
module cbsm_top_tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
	logic        ll_active_i = 1'b0, ll_ctl_wr_i = 1'b0, ll_ctl_wdata_i = 1'b0;
	logic        ll_out_wr_i = 1'b0, ll_out_wdata_i = 1'b0, look = 1'b0, ack_o, b0;
	logic [7:0]  adr_i = 8'h00, out_req = 8'h00, hi = 8'h00, plc_out_ctl_q_i, face, seen, o, p;
	logic [7:0]  backplane_fast_status_rd_o, plc_in_image_o;
	logic [3:0]  sel_i = 4'h0, fs_req = 4'h0, prog_req = 4'h0;
	logic [3:0]  backplane_fast_status_wr_i, plc_prog_ctl_q_i;
	logic [4:0]  ll_ctl_idx_i = 5'h00;
	logic [2:0]  ll_out_idx_i = 3'h0;
	logic [19:0] pin = 20'h0;
	logic [15:0] lo = 16'h0;
	logic [35:0] s;
	logic [31:0] dat_i = 32'h0, lf = 32'h365C, dat_o, r;
	logic [31:0] all_control_bits_word_o, control_bits_1_to_32_o;
	logic [31:0] expq[$];
	int          miscompares = 0, n_compared = 0, code;

	// ****************
	// harness
	// ****************
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	cbsm_top u_cbsm_top (
		.axis1_overtravel_pos_input_i(pin[0]),
		.axis1_overtravel_neg_input_i(pin[1]),
		.axis1_home_switch_input_i(pin[2]),
		.axis2_overtravel_pos_input_i(pin[3]),
		.axis2_overtravel_neg_input_i(pin[4]),
		.axis2_home_switch_input_i(pin[5]),
		.axis3_general_input_a_i(pin[6]),
		.axis3_general_input_b_i(pin[7]),
		.axis3_home_switch_input_i(pin[8]),
		.axis4_general_input_a_i(pin[9]),
		.axis4_general_input_b_i(pin[10]),
		.axis4_general_input_c_i(pin[11]),
		.strobe_level_i(pin[17:12]),
		.axis4_low_volt_input_a_i(pin[18]),
		.axis4_low_volt_input_b_i(pin[19]),
		.axis1_ssr_output_o(face[0]),
		.axis1_low_volt_output_o(face[1]),
		.axis2_ssr_output_o(face[2]),
		.axis2_low_volt_output_o(face[3]),
		.axis3_ssr_output_o(face[4]),
		.axis3_low_volt_output_o(face[5]),
		.axis4_ssr_output_o(face[6]),
		.axis4_low_volt_output_o(face[7]),
		.*
	);
	cbsm_plc_model u_cbsm_plc_model (
		.clk_i(clk_i),
		.fs_req_i(fs_req),
		.prog_req_i(prog_req),
		.out_req_i(out_req),
		.fs_rd_i(backplane_fast_status_rd_o),
		.fs_wr_o(backplane_fast_status_wr_i),
		.prog_o(plc_prog_ctl_q_i),
		.out_o(plc_out_ctl_q_i),
		.seen_o(seen)
	);

	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction : rnd
	// word expected from a source vector
	function automatic logic [31:0] ew(input logic [35:0] v);
		return {hi, v[23:22], v[35:30], lo};
	endfunction : ew
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_compared++;
		if (seen_v !== exp_v) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	// no fixed latency assumed, bounded wait for ack
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] m);
		int n;
		@(posedge clk_i);
		adr_i <= a;
		we_i <= w;
		dat_i <= d;
		sel_i <= m;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			miscompares++;
			print_verdict();
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(a, 1'b0, 32'h0, 4'hF);
	endtask : rd
	task automatic look_at(input logic [31:0] e);
		expq.push_back(e);
		look <= 1'b1;
		@(posedge clk_i);
		look <= 1'b0;
	endtask : look_at
	task automatic put_src(input logic [35:0] v);
		pin <= v[19:0];
		ll_active_i <= v[21];
		fs_req <= v[25:22];
		prog_req <= v[29:26];
		out_req[5:0] <= v[35:30];
	endtask : put_src
	task automatic out_wr(input logic [7:0] v);
		for (int j = 0; j < 8; j++) begin
			ll_out_wr_i <= 1'b1;
			ll_out_idx_i <= 3'(j);
			ll_out_wdata_i <= v[j];
			@(posedge clk_i);
		end
		ll_out_wr_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : out_wr

	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0)
			check(dat_o, expq.pop_front());
		if (look && expq.size() > 0)
			check({face, backplane_fast_status_rd_o, plc_in_image_o, seen}, expq.pop_front());
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int k = 0; k < 4; k++)
			rd(8'(4 * k), 32'h1414_1414);
		rd(8'h10, 32'h2120_1F1E);
		rd(8'h14, 32'h1716_2322);
		rd(8'h18, 32'h0);
		rd(8'h20, 32'h0);
		$display("test 1 done");
		r = rnd();
		s = {r[3:0], rnd()};
		put_src(s);
		out_req[7:6] <= r[7:6];
		repeat (4) @(posedge clk_i);
		rd(8'h1C, ew(s));
		look_at({r[7:6], s[35:30], 24'h0});
		$display("test 2 done");
		r = rnd();
		for (int i = 0; i < 32; i++) begin
			ll_ctl_wr_i <= 1'b1;
			ll_ctl_idx_i <= 5'(i);
			ll_ctl_wdata_i <= r[i];
			@(posedge clk_i);
		end
		ll_ctl_wr_i <= 1'b0;
		hi = r[31:24];
		lo = r[15:0];
		b0 = r[0];
		repeat (3) @(posedge clk_i);
		rd(8'h1C, ew(s));
		look_at({out_req[7:6], s[35:30], lo[7:0], lo[7:0], lo[7:0]});
		$display("test 3 done");
		for (int c = 0; c < 38; c++) begin
			code = (c == 37) ? 20 : c;
			r = rnd();
			s = {r[3:0], rnd()};
			put_src(s);
			wb(8'h00, 1'b1, {24'h0, 8'(code)}, 4'h1);
			repeat (4) @(posedge clk_i);
			lo[0] = (code == 20) ? b0 : (code < 36) ? s[code] : 1'b0;
			rd(8'h1C, ew(s));
		end
		rd(8'h00, 32'h1414_1414);
		$display("test 4 done");
		r = rnd();
		o = r[7:0];
		p = r[15:8];
		out_req <= o;
		out_wr(p);
		look_at({o, lo[7:0], lo[7:0], lo[7:0]});
		wb(8'h18, 1'b1, 32'hA5, 4'hF);
		repeat (2) @(posedge clk_i);
		// writes refused under plc control must not show once handed over
		look_at({o & ~8'hA5, lo[7:0], lo[7:0], lo[7:0]});
		out_wr(p);
		look_at({(o & ~8'hA5) | (p & 8'hA5), lo[7:0], lo[7:0], lo[7:0]});
		rd(8'h18, 32'hA5);
		$display("test 5 done");
		repeat (2) @(posedge clk_i);
		check(32'(expq.size()), 32'h0);
		print_verdict();
	end
endmodule : cbsm_top_tb
bind cbsm_top cbsm_top_chk u_cbsm_top_chk (.*);
`default_nettype wire
